// ### hw/jid_pkg.sv
// constants and types for the scan-port instruction decoder
// What this block does
// R01 - sample/preload captures pins into scan register, preloads pattern for later drive
// R02 - external test drives scan register onto outputs, captures inputs
// R03 - all-ones code puts one-bit bypass stage between data in and out
// R04 - user-code instruction shifts out the 32-bit user-code register
// R05 - identification instruction shifts out the identification register
// R06 - high-impedance instruction selects bypass and floats all user pins
// R07 - clamp selects bypass and holds pins at scan register levels
// R08 - bus-hold or weak pull-up overrides floating during highz, clamp, external test
// R09 - soft reconfiguration acts like a low pulse on reconfig pin, pin untouched
// R10 - I/O-standard load accepted anytime; aborts configuration in progress
// R11 - I/O-standard load holds config status low until reconfiguration
// R12 - controller runs scan tests only outside configuration; this block does not gate them on config_busy_in
// R13 - clock-synthesizer bits in chain until configuration completes
// R14 - user-code register holds value supplied with configuration data
// R15 - instruction register is ten bits wide
// R16 - id code: version, part number, manufacturer field, lsb one
// R17 - standard tap state machine; unknown codes select bypass
package jid_pkg;

    // ************************************************
    // instruction register and codes
    // ************************************************
    localparam int         JID_IR_W          = 10;
    localparam logic [9:0] JID_OP_EXTEST     = 10'h000;
    localparam logic [9:0] JID_OP_SOFTRECFG  = 10'h001;
    localparam logic [9:0] JID_OP_SAMPLE     = 10'h005;
    localparam logic [9:0] JID_OP_IDCODE     = 10'h006;
    localparam logic [9:0] JID_OP_USERCODE   = 10'h007;
    localparam logic [9:0] JID_OP_CLAMP      = 10'h00a;
    localparam logic [9:0] JID_OP_HIGHZ      = 10'h00b;
    localparam logic [9:0] JID_OP_CONFIG_IO  = 10'h00d;
    localparam logic [9:0] JID_OP_BYPASS     = 10'h3ff;
    localparam logic [9:0] JID_IR_CAPTURE    = 10'h001;

    // ************************************************
    // chain lengths and id code fields
    // ************************************************
    localparam int         JID_UC_W          = 32;
    localparam int         JID_BSR_W         = 8;
    localparam int         JID_PLL_W         = 4;
    localparam int         JID_IOSTD_W       = 8;
    localparam logic [3:0]  JID_ID_VERSION   = 4'h0;     // arbitrary value
    localparam logic [15:0] JID_ID_PART      = 16'h1234; // arbitrary value
    localparam logic [10:0] JID_ID_MAKER     = 11'h055;  // arbitrary value
    localparam logic        JID_ID_LSB       = 1'b1;

    // ************************************************
    // tap controller states
    // ************************************************
    typedef enum logic [15:0] {
        JID_RESET   = 16'h0001, JID_IDLE    = 16'h0002,
        JID_SEL_DR  = 16'h0004, JID_CAP_DR  = 16'h0008,
        JID_SH_DR   = 16'h0010, JID_EX1_DR  = 16'h0020,
        JID_PA_DR   = 16'h0040, JID_EX2_DR  = 16'h0080,
        JID_UPD_DR  = 16'h0100, JID_SEL_IR  = 16'h0200,
        JID_CAP_IR  = 16'h0400, JID_SH_IR   = 16'h0800,
        JID_EX1_IR  = 16'h1000, JID_PA_IR   = 16'h2000,
        JID_EX2_IR  = 16'h4000, JID_UPD_IR  = 16'h8000
    } jid_state_t;

endpackage

// ### hw/jid_top.sv
// scan-port tap controller, instruction decode and data-register selection
`timescale 1ns/1ps
`default_nettype none
module jid_top
    import jid_pkg::*;
(
    // system clock domain
    input  wire logic                   clk_sys_in,
    input  wire logic                   reset_n_in,
    input  wire logic                   clk_en_in,
    // test port, test clock domain
    input  wire logic                   tck_in,
    input  wire logic                   trst_n_in,
    input  wire logic                   tms_in,
    input  wire logic                   tdi_in,
    output logic                        tdo_out,
    output logic                        tdo_oe_out,
    // pins and configuration status, test clock domain
    input  wire logic [JID_BSR_W-1:0]   pin_level_in,
    input  wire logic [JID_BSR_W-1:0]   pin_hold_en_in,
    input  wire logic [JID_UC_W-1:0]    usercode_in,
    output logic [JID_BSR_W-1:0]        pin_drive_out,
    output logic [JID_BSR_W-1:0]        pin_oe_out,
    output logic [JID_BSR_W-1:0]        pin_keeper_out,
    output logic                        test_pins_own_out,
    // configuration control, system clock domain
    input  wire logic                   config_busy_in,
    input  wire logic                   config_done_in,
    output logic                        reconfig_pulse_out,
    output logic                        config_abort_out,
    output logic                        config_status_output,
    output logic [JID_IOSTD_W-1:0]      io_standard_out
);

    // ************************************************
    // test clock domain
    // ************************************************
    jid_state_t                 st_r;
    jid_state_t                 st_nxt;
    logic [JID_IR_W-1:0]        ir_sh_r;
    logic [JID_IR_W-1:0]        ir_r;
    logic                       byp_r;
    logic [31:0]                dr_sh_r;
    logic [JID_BSR_W-1:0]       bsr_sh_r;
    logic [JID_BSR_W-1:0]       bsr_upd_r;
    logic [JID_PLL_W-1:0]       pll_sh_r;
    logic [JID_PLL_W-1:0]       pll_r;
    logic [JID_IOSTD_W-1:0]     iostd_sh_r;
    logic [JID_IOSTD_W-1:0]     iostd_r;
    logic                       tdo_r;
    logic                       recfg_tgl_r;
    logic                       cfgio_tgl_r;
    logic                       iostd_tgl_r;
    logic                       done_s1_r;
    logic                       done_s2_r;
    logic                       sel_bsr;
    logic                       sel_pll;
    logic                       dr_ser;

    // tap next state
    // R17 standard tap walk
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            JID_RESET:  st_nxt = tms_in ? JID_RESET  : JID_IDLE;
            JID_IDLE:   st_nxt = tms_in ? JID_SEL_DR : JID_IDLE;
            JID_SEL_DR: st_nxt = tms_in ? JID_SEL_IR : JID_CAP_DR;
            JID_CAP_DR: st_nxt = tms_in ? JID_EX1_DR : JID_SH_DR;
            JID_SH_DR:  st_nxt = tms_in ? JID_EX1_DR : JID_SH_DR;
            JID_EX1_DR: st_nxt = tms_in ? JID_UPD_DR : JID_PA_DR;
            JID_PA_DR:  st_nxt = tms_in ? JID_EX2_DR : JID_PA_DR;
            JID_EX2_DR: st_nxt = tms_in ? JID_UPD_DR : JID_SH_DR;
            JID_UPD_DR: st_nxt = tms_in ? JID_SEL_DR : JID_IDLE;
            JID_SEL_IR: st_nxt = tms_in ? JID_RESET  : JID_CAP_IR;
            JID_CAP_IR: st_nxt = tms_in ? JID_EX1_IR : JID_SH_IR;
            JID_SH_IR:  st_nxt = tms_in ? JID_EX1_IR : JID_SH_IR;
            JID_EX1_IR: st_nxt = tms_in ? JID_UPD_IR : JID_PA_IR;
            JID_PA_IR:  st_nxt = tms_in ? JID_EX2_IR : JID_PA_IR;
            JID_EX2_IR: st_nxt = tms_in ? JID_UPD_IR : JID_SH_IR;
            JID_UPD_IR: st_nxt = tms_in ? JID_SEL_DR : JID_IDLE;
            default:    st_nxt = JID_RESET;
        endcase
    end

    // tap state register
    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            st_r <= JID_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // configuration done seen from the test clock
    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            done_s1_r <= 1'b0;
            done_s2_r <= 1'b0;
        end else begin
            done_s1_r <= config_done_in;
            done_s2_r <= done_s1_r;
        end
    end

    // R15 ten-bit instruction shift and update
    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            ir_sh_r <= JID_IR_CAPTURE;
            ir_r    <= JID_OP_IDCODE;
        end else if (st_r == JID_RESET) begin
            ir_r <= JID_OP_IDCODE;
        end else if (st_r == JID_CAP_IR) begin
            ir_sh_r <= JID_IR_CAPTURE;
        end else if (st_r == JID_SH_IR) begin
            ir_sh_r <= {tdi_in, ir_sh_r[JID_IR_W-1:1]};
        end else if (st_r == JID_UPD_IR) begin
            ir_r <= ir_sh_r;
        end
    end

    // R13 pll bits in chain until configured
    assign sel_bsr = (ir_r == JID_OP_SAMPLE) || (ir_r == JID_OP_EXTEST);
    assign sel_pll = sel_bsr && !done_s2_r;

    // scan register, pll bits and io standard chain
    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            bsr_sh_r   <= '0;
            pll_sh_r   <= '0;
            iostd_sh_r <= '0;
        end else if (st_r == JID_CAP_DR) begin
            // R01 R02 capture pin levels
            bsr_sh_r   <= pin_level_in;
            pll_sh_r   <= pll_r;
            iostd_sh_r <= iostd_r;
        end else if (st_r == JID_SH_DR) begin
            if (ir_r == JID_OP_CONFIG_IO) begin
                iostd_sh_r <= {tdi_in, iostd_sh_r[JID_IOSTD_W-1:1]};
            end else if (sel_pll) begin
                pll_sh_r <= {tdi_in, pll_sh_r[JID_PLL_W-1:1]};
                bsr_sh_r <= {pll_sh_r[0], bsr_sh_r[JID_BSR_W-1:1]};
            end else if (sel_bsr) begin
                bsr_sh_r <= {tdi_in, bsr_sh_r[JID_BSR_W-1:1]};
            end
        end
    end

    // update stage of the chains
    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            bsr_upd_r <= '0;
            pll_r     <= '0;
            iostd_r   <= '0;
        end else if (st_r == JID_UPD_DR) begin
            // R01 preload pattern for later driving
            if (sel_bsr) begin
                bsr_upd_r <= bsr_sh_r;
            end
            if (sel_pll) begin
                pll_r <= pll_sh_r;
            end
            if (ir_r == JID_OP_CONFIG_IO) begin
                iostd_r <= iostd_sh_r;
            end
        end
    end

    // bypass, id and user-code shift register
    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            byp_r   <= 1'b0;
            dr_sh_r <= '0;
        end else if (st_r == JID_CAP_DR) begin
            // R03 R06 R07 bypass captures zero
            byp_r <= 1'b0;
            if (ir_r == JID_OP_IDCODE) begin
                // R05 R16 id code layout
                dr_sh_r <= {JID_ID_VERSION, JID_ID_PART, JID_ID_MAKER, JID_ID_LSB};
            end else if (ir_r == JID_OP_USERCODE) begin
                // R04 R14 configured user code
                dr_sh_r <= usercode_in;
            end
        end else if (st_r == JID_SH_DR) begin
            byp_r   <= tdi_in;
            dr_sh_r <= {tdi_in, dr_sh_r[31:1]};
        end
    end

    // R17 serial path select, unknown codes bypass
    always_comb begin
        if (ir_r == JID_OP_IDCODE || ir_r == JID_OP_USERCODE) begin
            dr_ser = dr_sh_r[0];
        end else if (ir_r == JID_OP_CONFIG_IO) begin
            dr_ser = iostd_sh_r[0];
        end else if (sel_bsr) begin
            dr_ser = bsr_sh_r[0];
        end else begin
            dr_ser = byp_r;
        end
    end

    // data out changes on the falling test clock edge
    always_ff @(negedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            tdo_r      <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else begin
            tdo_r      <= (st_r == JID_SH_IR) ? ir_sh_r[0] : dr_ser;
            tdo_oe_out <= (st_r == JID_SH_IR) || (st_r == JID_SH_DR);
        end
    end
    assign tdo_out = tdo_r;

    // R02 R06 R07 R08 pin ownership and drive
    always_comb begin
        test_pins_own_out = 1'b0;
        pin_drive_out     = bsr_upd_r;
        pin_oe_out        = '0;
        pin_keeper_out    = '0;
        if (ir_r == JID_OP_EXTEST || ir_r == JID_OP_CLAMP) begin
            test_pins_own_out = 1'b1;
            pin_oe_out        = '1;
            pin_keeper_out    = pin_hold_en_in;
        end else if (ir_r == JID_OP_HIGHZ) begin
            test_pins_own_out = 1'b1;
            pin_keeper_out    = pin_hold_en_in;
        end
    end

    // event toggles toward the system clock
    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            recfg_tgl_r <= 1'b0;
            cfgio_tgl_r <= 1'b0;
        end else if (st_r == JID_UPD_IR) begin
            if (ir_sh_r == JID_OP_SOFTRECFG) begin
                recfg_tgl_r <= ~recfg_tgl_r;
            end
            if (ir_sh_r == JID_OP_CONFIG_IO) begin
                cfgio_tgl_r <= ~cfgio_tgl_r;
            end
        end
    end

    // io standard update event, word held stable until the next one
    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            iostd_tgl_r <= 1'b0;
        end else if (st_r == JID_UPD_DR && ir_r == JID_OP_CONFIG_IO) begin
            iostd_tgl_r <= ~iostd_tgl_r;
        end
    end

    // ************************************************
    // system clock domain
    // ************************************************
    logic [2:0]                 recfg_sy_r;
    logic [2:0]                 cfgio_sy_r;
    logic                       status_low_r;
    logic                       recfg_ev;
    logic                       cfgio_ev;
    logic [2:0]                 iostd_sy_r;
    logic                       iostd_ev;

    // toggle synchronisers, third stage for edge detect
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            recfg_sy_r <= '0;
            cfgio_sy_r <= '0;
            iostd_sy_r <= '0;
        end else if (clk_en_in) begin
            recfg_sy_r <= {recfg_sy_r[1:0], recfg_tgl_r};
            cfgio_sy_r <= {cfgio_sy_r[1:0], cfgio_tgl_r};
            iostd_sy_r <= {iostd_sy_r[1:0], iostd_tgl_r};
        end
    end
    assign recfg_ev = recfg_sy_r[2] ^ recfg_sy_r[1];
    assign iostd_ev = iostd_sy_r[2] ^ iostd_sy_r[1];
    assign cfgio_ev = cfgio_sy_r[2] ^ cfgio_sy_r[1];

    // R09 one-cycle reconfig request, pin left alone
    // R10 abort configuration in progress
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reconfig_pulse_out <= 1'b0;
            config_abort_out   <= 1'b0;
            io_standard_out    <= '0;
        end else if (clk_en_in) begin
            reconfig_pulse_out <= recfg_ev;
            config_abort_out   <= cfgio_ev && config_busy_in;
            if (iostd_ev) begin
                io_standard_out <= iostd_r; // word settled long before the event
            end
        end
    end

    // R11 status held low until reconfiguration, set wins
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_low_r <= 1'b0;
        end else if (clk_en_in) begin
            if (cfgio_ev) begin
                status_low_r <= 1'b1;
            end else if (recfg_ev) begin
                status_low_r <= 1'b0;
            end
        end
    end
    assign config_status_output = !status_low_r;

endmodule
`default_nettype wire

// ### bench/jid_top_properties.sv
// concurrent checks on the scan-port decoder outputs
`timescale 1ns/1ps
`default_nettype none
module jid_top_chk
    import jid_pkg::*;
(
    // system domain
    input wire logic                 clk_sys_in,
    input wire logic                 reset_n_in,
    input wire logic                 config_busy_in,
    input wire logic                 reconfig_pulse_out,
    input wire logic                 config_abort_out,
    input wire logic                 config_status_output,
    // test clock domain
    input wire logic                 tck_in,
    input wire logic                 trst_n_in,
    // pin control
    input wire logic [JID_BSR_W-1:0] pin_hold_en_in,
    input wire logic [JID_BSR_W-1:0] pin_oe_out,
    input wire logic [JID_BSR_W-1:0] pin_keeper_out,
    input wire logic                 test_pins_own_out
);
    // ************************************************
    // checks, pin controls sampled on the test clock
    // ************************************************
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    AST_PULSE_ONE:
        assert property (reconfig_pulse_out |=> !reconfig_pulse_out)
        else $error("reconfig pulse wider than one cycle");
    AST_ABORT_ONE:
        assert property (config_abort_out |=> !config_abort_out)
        else $error("abort pulse wider than one cycle");
    AST_ABORT_BUSY:
        assert property (config_abort_out |-> config_busy_in)
        else $error("abort while configuration idle");
    AST_ABORT_LOW:
        assert property (config_abort_out |-> ##[0:4] !config_status_output)
        else $error("status not low after io load");
    AST_STATUS_RISE:
        assert property ($rose(config_status_output) |-> reconfig_pulse_out
            || $past(reconfig_pulse_out) || $past(reconfig_pulse_out, 2))
        else $error("status released without reconfig");
    AST_OE_ALL:
        assert property (@(posedge tck_in) disable iff (!trst_n_in)
            pin_oe_out != '0 |-> pin_oe_out == {JID_BSR_W{1'b1}})
        else $error("partial pin drive");
    AST_OE_OWN:
        assert property (@(posedge tck_in) disable iff (!trst_n_in)
            pin_oe_out != '0 |-> test_pins_own_out)
        else $error("pins driven without ownership");
    AST_KEEP_ON:
        assert property (@(posedge tck_in) disable iff (!trst_n_in)
            test_pins_own_out |-> pin_keeper_out == pin_hold_en_in)
        else $error("keeper not following hold enable");
    AST_KEEP_OFF:
        assert property (@(posedge tck_in) disable iff (!trst_n_in)
            !test_pins_own_out |-> pin_keeper_out == '0)
        else $error("keeper active outside test");
    // main scenarios
    cover property (reconfig_pulse_out);
    cover property (config_abort_out);
    cover property (@(posedge tck_in) test_pins_own_out && pin_oe_out == '0);
endmodule
bind jid_top jid_top_chk i_chk (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .config_busy_in(config_busy_in),
    .reconfig_pulse_out(reconfig_pulse_out), .config_abort_out(config_abort_out),
    .config_status_output(config_status_output), .pin_hold_en_in(pin_hold_en_in),
    .tck_in(tck_in), .trst_n_in(trst_n_in),
    .pin_oe_out(pin_oe_out), .pin_keeper_out(pin_keeper_out),
    .test_pins_own_out(test_pins_own_out)
);
`default_nettype wire

// ### bench/jid_host.sv
// scan controller model driving the test port
`timescale 1ns/1ps
`default_nettype none
module jid_host (
    // test port
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out,
    input  wire logic tdo_in
);
    real gap_ns = 2.7; // idle before each frame, tck still
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // one tck period, tdo taken at rise
    task automatic step(input logic m, input logic d, output logic o);
        tms_out = m;
        tdi_out = d;
        #80 tck_out = 1'b1;
        o = tdo_in;
        #80 tck_out = 1'b0;
    endtask
    // data line toggles when not shifting
    task automatic walk(input logic m);
        logic o;
        step(m, ~tdi_out, o);
    endtask
    task automatic tap_reset();
        repeat (5) walk(1'b1);
        walk(1'b0);
    endtask
    // capture, shift lsb first, update, idle
    task automatic shift(input logic is_ir, input int n, input logic [31:0] din,
                         output logic [31:0] dout);
        dout = '0;
        #(gap_ns);
        walk(1'b1);
        if (is_ir) walk(1'b1);
        walk(1'b0);
        walk(1'b0);
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], dout[i]);
        walk(1'b1);
        walk(1'b0);
    endtask
    task automatic ir(input logic [9:0] code, output logic [9:0] cap);
        logic [31:0] w;
        shift(1'b1, 10, {22'h0, code}, w);
        cap = w[9:0];
    endtask
    task automatic dr(input logic [31:0] din, output logic [31:0] dout);
        shift(1'b0, 32, din, dout);
    endtask
endmodule
`default_nettype wire

// ### bench/jid_top_tb.sv
// self-checking bench for the scan-port decoder
`timescale 1ns/1ps
`default_nettype none
module jid_top_tb;
    import jid_pkg::*;
    logic        clk_sys_in = 1'b0, reset_n_in = 1'b1, trst_n_in = 1'b1, clk_en_in = 1'b1;
    logic        tck, tms, tdi, tdo, config_busy_in = 1'b0, config_done_in = 1'b0;
    logic [7:0]  pin_level_in = 8'h00, hold = 8'h96, pin_drive_out, pin_oe_out, pin_keeper_out;
    logic [7:0]  io_standard_out;
    logic [31:0] ucode = 32'h5ee4_d00d, d;
    logic        test_pins_own_out, reconfig_pulse_out, config_abort_out, config_status_output;
    int          err_count = 0, checks_done = 0, n_pulse = 0, n_abort = 0;
    jid_top i_dut (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
        .tck_in(tck), .trst_n_in(trst_n_in), .tms_in(tms), .tdi_in(tdi),
        .tdo_out(tdo), .tdo_oe_out(), .pin_level_in(pin_level_in),
        .pin_hold_en_in(hold), .usercode_in(ucode), .pin_drive_out(pin_drive_out),
        .pin_oe_out(pin_oe_out), .pin_keeper_out(pin_keeper_out),
        .test_pins_own_out(test_pins_own_out), .config_busy_in(config_busy_in),
        .config_done_in(config_done_in), .reconfig_pulse_out(reconfig_pulse_out),
        .config_abort_out(config_abort_out), .config_status_output(config_status_output),
        .io_standard_out(io_standard_out)
    );
    jid_host i_host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));
    // system clock
    always #4 clk_sys_in = ~clk_sys_in;
    // count one-cycle pulses
    always @(negedge clk_sys_in) begin
        if (reconfig_pulse_out === 1'b1) n_pulse++;
        if (config_abort_out === 1'b1) n_abort++;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        if (err_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic sync();
        @(posedge clk_sys_in);
        #1;
    endtask
    task automatic ld(input logic [9:0] code);
        logic [9:0] cap;
        i_host.ir(code, cap);
        chk("ir_capture", {22'h0, cap}, {22'h0, JID_IR_CAPTURE});
    endtask
    // marker behind zeros shows the chain length
    task automatic chain_len(input logic [9:0] code, input int len);
        ld(code);
        i_host.dr(32'h0001_0000, d);
        chk("chain_len", d >> 16, 32'h1 << len);
    endtask
    task automatic t_idcode();
        i_host.tap_reset();
        i_host.dr(32'h0, d);
        chk("idcode", d, {JID_ID_VERSION, JID_ID_PART, JID_ID_MAKER, 1'b1});
    endtask
    task automatic t_pll();
        chain_len(JID_OP_SAMPLE, JID_BSR_W + JID_PLL_W);
        sync();
        config_done_in = 1'b1;
        chain_len(JID_OP_SAMPLE, JID_BSR_W);
    endtask
    task automatic t_codes();
        logic [9:0] code [6];
        int         len [6];
        logic [5:0] own, oe;
        code = '{JID_OP_BYPASS, JID_OP_HIGHZ, JID_OP_CLAMP, 10'h2a5, JID_OP_EXTEST, JID_OP_SAMPLE};
        len = '{1, 1, 1, 1, JID_BSR_W, JID_BSR_W};
        own = 6'b010110;
        oe = 6'b010100;
        for (int i = 0; i < 6; i++) begin
            chain_len(code[i], len[i]);
            chk("pins_own", {31'h0, test_pins_own_out}, {31'h0, own[i]});
            chk("pin_oe", pin_oe_out, {8{oe[i]}});
            chk("keeper", pin_keeper_out, own[i] ? hold : 8'h00);
        end
    endtask
    task automatic t_capture();
        logic [9:0] code [2];
        logic [7:0] lvl [2], pat [2];
        code = '{JID_OP_SAMPLE, JID_OP_EXTEST};
        lvl = '{8'h5a, 8'hc3};
        pat = '{8'ha3, 8'h69};
        for (int i = 0; i < 2; i++) begin
            sync();
            pin_level_in = lvl[i];
            ld(code[i]);
            i_host.dr({pat[i], 24'h0}, d);
            chk("capture", d[7:0], lvl[i]);
            chk("pin_drive", pin_drive_out, pat[i]);
        end
    endtask
    task automatic t_usercode();
        ld(JID_OP_USERCODE);
        i_host.dr(32'h0, d);
        chk("usercode", d, ucode);
    endtask
    task automatic t_cfgio();
        int a0, p0;
        a0 = n_abort;
        p0 = n_pulse;
        sync();
        config_busy_in = 1'b1;
        ld(JID_OP_CONFIG_IO);
        chk("abort", n_abort - a0, 1);
        chk("status", {31'h0, config_status_output}, 0);
        sync();
        config_busy_in = 1'b0;
        i_host.gap_ns = 500.3;
        i_host.dr(32'h3c00_0000, d);
        chk("io_std", io_standard_out, 8'h3c);
        ld(JID_OP_CONFIG_IO);
        chk("abort", n_abort - a0, 1);
        chk("status", {31'h0, config_status_output}, 0);
        ld(JID_OP_SOFTRECFG);
        chk("pulse", n_pulse - p0, 1);
        chk("status", {31'h0, config_status_output}, 1);
    endtask
    // watchdog
    initial begin
        #600_000;
        err_count++;
        conclude();
    end
    initial begin
        #1;
        reset_n_in = 1'b0; // real falling edge so async resets fire
        trst_n_in = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        reset_n_in = 1'b1;
        trst_n_in = 1'b1;
        repeat (3) @(posedge clk_sys_in);
        t_idcode();
        t_pll();
        t_codes();
        t_capture();
        t_usercode();
        t_cfgio();
        conclude();
    end
endmodule
`default_nettype wire
